// File: logic/bmwd_top.sv
/*
  Memory window decode and parity status logging for one virtual bridge port.
  Assumes an APB master on pclk, and an upstream request source and poison
  event source that run on pclk as well, so no synchroniser is needed.
*/
// The APB register port is this design's own decision.
// Overview of operation
// - Non-prefetchable hit when A[31:20] within base..limit
// - Window base low 20 bits taken zero
// - Window limit low 20 bits taken ones
// - Bits 15:4 writable address field, reset zero
// - Non-prefetchable low nibble reads zero
// - Prefetchable hit when upper address within window
// - Prefetchable low nibble returns 64-bit code
// - Upper base/limit writable, used in compare
// - Upper halves read zero if 32-bit only
// - Upper I/O base/limit registers read zero, writes ignored
// - Parity flags logged per direction table
// - Detected flag need not cover master events
// - Fast clock bit and reserved bits zero
// - Poisoned packet sets secondary detected parity
// - Secondary master parity gated by response enable
`timescale 1ns/10ps
module bmwd_top (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Upstream request and decode answer
  input  wire bmwd_pkg::bmwd_req_t    req,
  output bmwd_pkg::bmwd_resp_t        resp,
  // Poison events from the port
  input  wire bmwd_pkg::bmwd_poison_t poison,
  // Interrupt
  output logic                       irq
);

  // ==========================================================================
  // Bus decode
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  idx;
  logic        mapped;
  logic [31:0] next_prdata;

  assign access = psel && penable && !pready;
  assign wr_en  = psel && penable && pready && pwrite;
  assign rd_en  = access && !pwrite;
  assign idx    = paddr[9:2];

  // The low address bits paddr[1:0] are ignored, as the read mux does through idx.
  function automatic logic hit_idx(input logic [11:0] a, input logic [7:0] i);
    hit_idx = ({a[11:2], 2'b00} == bmwd_pkg::bmwd_byte_addr(i));
  endfunction : hit_idx

  // ==========================================================================
  // Window registers
  logic [11:0] np_base;
  logic [11:0] np_limit;
  logic [11:0] pf_base;
  logic [11:0] pf_limit;
  logic [31:0] pf_base_up;
  logic [31:0] pf_lim_up;
  logic        presp_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_base  <= bmwd_pkg::FIELD_RST;
      np_limit <= bmwd_pkg::FIELD_RST;
      pf_base  <= bmwd_pkg::FIELD_RST;
      pf_limit <= bmwd_pkg::FIELD_RST;
    end else if (wr_en) begin
      if (hit_idx(paddr, bmwd_pkg::IDX_NP_BASE)) begin
        np_base <= pwdata[15:4];
      end
      if (hit_idx(paddr, bmwd_pkg::IDX_NP_LIMIT)) begin
        np_limit <= pwdata[15:4];
      end
      if (hit_idx(paddr, bmwd_pkg::IDX_PF_BASE)) begin
        pf_base <= pwdata[15:4];
      end
      if (hit_idx(paddr, bmwd_pkg::IDX_PF_LIMIT)) begin
        pf_limit <= pwdata[15:4];
      end
    end
  end

  // The upper halves only exist as storage when the 64-bit code is reported.
  generate
    if (bmwd_pkg::PF_WIDTH_CODE == bmwd_pkg::WIDTH_64) begin : g_upper
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pf_base_up <= bmwd_pkg::UPPER_RST;
          pf_lim_up  <= bmwd_pkg::UPPER_RST;
        end else if (wr_en) begin
          if (hit_idx(paddr, bmwd_pkg::IDX_PF_BASE_UP)) begin
            pf_base_up <= pwdata;
          end
          if (hit_idx(paddr, bmwd_pkg::IDX_PF_LIM_UP)) begin
            pf_lim_up <= pwdata;
          end
        end
      end
    end else begin : g_no_upper
      assign pf_base_up = bmwd_pkg::UPPER_RST;
      assign pf_lim_up  = bmwd_pkg::UPPER_RST;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presp_en <= 1'b0;
    end else if (wr_en && hit_idx(paddr, bmwd_pkg::IDX_BRIDGE_CTL)) begin
      presp_en <= pwdata[bmwd_pkg::PRESP_EN_BIT];
    end
  end

  // ==========================================================================
  // Address decode
  // Overlapping windows are not checked; both hits are reported as seen.
  logic [63:0] np_lo;
  logic [63:0] np_hi;
  logic [63:0] pf_lo;
  logic [63:0] pf_hi;
  logic        np_on;
  logic        pf_on;
  logic        np_match;
  logic        pf_match;

  assign np_lo = {32'h0000_0000, np_base, 20'h0_0000};
  assign np_hi = {32'h0000_0000, np_limit, 20'hF_FFFF};
  assign pf_lo = {pf_base_up, pf_base, 20'h0_0000};
  assign pf_hi = {pf_lim_up, pf_limit, 20'hF_FFFF};
  assign np_on = (np_lo <= np_hi);
  assign pf_on = (pf_lo <= pf_hi);
  assign np_match = np_on && (req.addr >= np_lo) && (req.addr <= np_hi);
  assign pf_match = pf_on && (req.addr >= pf_lo) && (req.addr <= pf_hi);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp <= '0;
    end else begin
      resp.valid   <= req.valid;
      resp.np_hit  <= req.valid && np_match;
      resp.pf_hit  <= req.valid && pf_match;
      resp.forward <= req.valid && (np_match || pf_match);
    end
  end

  // ==========================================================================
  // Parity status flags
  logic pri_det;
  logic pri_mst;
  logic sec_det;
  logic sec_mst;
  logic set_pri_det;
  logic set_pri_mst;
  logic set_sec_det;
  logic set_sec_mst;
  logic clr_pri;
  logic clr_sec;

  // Every master event except ib_write_poisoned is also logged as detected here, which is allowed.
  assign set_pri_det = poison.ob_posted || poison.ob_compl;
  assign set_pri_mst = poison.ob_compl;
  assign set_sec_det = poison.ib_posted || poison.ib_compl;
  assign set_sec_mst = presp_en && (poison.ib_compl || poison.ib_write_poisoned);
  assign clr_pri = wr_en && hit_idx(paddr, bmwd_pkg::IDX_PRI_STATUS);
  assign clr_sec = wr_en && hit_idx(paddr, bmwd_pkg::IDX_SEC_STATUS);

  // Set beats a same-cycle write-one clear so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_det <= 1'b0;
      pri_mst <= 1'b0;
    end else begin
      pri_det <= set_pri_det || (pri_det && !(clr_pri && pwdata[bmwd_pkg::DET_PARITY_BIT]));
      pri_mst <= set_pri_mst || (pri_mst && !(clr_pri && pwdata[bmwd_pkg::MST_PARITY_BIT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_det <= 1'b0;
      sec_mst <= 1'b0;
    end else begin
      sec_det <= set_sec_det || (sec_det && !(clr_sec && pwdata[bmwd_pkg::DET_PARITY_BIT]));
      sec_mst <= set_sec_mst || (sec_mst && !(clr_sec && pwdata[bmwd_pkg::MST_PARITY_BIT]));
    end
  end

  // ==========================================================================
  // Interrupt status, enable and output
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;

  assign irq_set = {set_sec_mst, set_sec_det, set_pri_mst, set_pri_det};
  assign irq_clr = (wr_en && hit_idx(paddr, bmwd_pkg::IDX_IRQ_CLEAR)) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= bmwd_pkg::IRQ_RST;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= bmwd_pkg::IRQ_RST;
    end else if (wr_en && hit_idx(paddr, bmwd_pkg::IDX_IRQ_ENABLE)) begin
      irq_enable <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped      = 1'b1;
    case (idx)
      bmwd_pkg::IDX_NP_BASE:    next_prdata = {16'h0000, np_base, 4'h0};
      bmwd_pkg::IDX_NP_LIMIT:   next_prdata = {16'h0000, np_limit, 4'h0};
      bmwd_pkg::IDX_PF_BASE:    next_prdata = {16'h0000, pf_base, bmwd_pkg::PF_WIDTH_CODE};
      bmwd_pkg::IDX_PF_LIMIT:   next_prdata = {16'h0000, pf_limit, bmwd_pkg::PF_WIDTH_CODE};
      bmwd_pkg::IDX_PF_BASE_UP: next_prdata = pf_base_up;
      bmwd_pkg::IDX_PF_LIM_UP:  next_prdata = pf_lim_up;
      bmwd_pkg::IDX_IO_BASE_UP: next_prdata = 32'h0000_0000;
      bmwd_pkg::IDX_IO_LIM_UP:  next_prdata = 32'h0000_0000;
      bmwd_pkg::IDX_PRI_STATUS: begin
        next_prdata[bmwd_pkg::DET_PARITY_BIT] = pri_det;
        next_prdata[bmwd_pkg::MST_PARITY_BIT] = pri_mst;
      end
      bmwd_pkg::IDX_SEC_STATUS: begin
        // Fast clock bit and reserved bits stay at zero.
        next_prdata[bmwd_pkg::DET_PARITY_BIT] = sec_det;
        next_prdata[bmwd_pkg::MST_PARITY_BIT] = sec_mst;
      end
      bmwd_pkg::IDX_BRIDGE_CTL: next_prdata[bmwd_pkg::PRESP_EN_BIT] = presp_en;
      bmwd_pkg::IDX_IRQ_STATUS: next_prdata[3:0] = irq_status;
      bmwd_pkg::IDX_IRQ_CLEAR:  next_prdata = 32'h0000_0000;
      bmwd_pkg::IDX_IRQ_ENABLE: next_prdata[3:0] = irq_enable;
      default:                  mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // One wait state keeps prdata and pready straight from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= rd_en && mapped ? next_prdata : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  a_np_window_hit: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && (req.addr[63:32] == 32'h0) && (np_base <= np_limit)
      && (req.addr[31:20] >= np_base) && (req.addr[31:20] <= np_limit)
      |=> resp.np_hit && resp.forward)
    else $error("in-window access not forwarded");

  a_np_base_edge: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && (np_base != 12'h000) && (np_base <= np_limit)
      && (req.addr == {32'h0, np_base, 20'h0_0000} - 64'h1)
      |=> !resp.np_hit)
    else $error("address below base hit window");

  a_np_limit_edge: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && (np_base <= np_limit) && (req.addr == {32'h0, np_limit, 20'hF_FFFF})
      |=> resp.np_hit)
    else $error("last byte of window missed");

  a_np_low_nibble: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (idx == bmwd_pkg::IDX_NP_LIMIT) && (paddr[11:10] == 2'b00)
      |=> prdata[3:0] == 4'h0 && prdata[15:4] == $past(np_limit))
    else $error("limit readback wrong");

  a_pf_width_code: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (idx == bmwd_pkg::IDX_PF_BASE) && (paddr[11:10] == 2'b00)
      |=> prdata[3:0] == 4'h1)
    else $error("capability code not 64-bit");

  a_pf_upper_cmp: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && (req.addr[63:32] > pf_lim_up) |=> !resp.pf_hit)
    else $error("upper address above limit hit");

  a_pf_hit: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && pf_on && ({req.addr[63:20]} >= {pf_base_up, pf_base})
      && ({req.addr[63:20]} <= {pf_lim_up, pf_limit}) |=> resp.pf_hit [*1] ##0 resp.forward)
    else $error("prefetchable hit missed");

  a_window_off: assert property (@(posedge pclk) disable iff (!presetn)
    (np_base > np_limit) && $stable(np_base) && $stable(np_limit) |=> !resp.np_hit)
    else $error("disabled window forwarded");

  a_sec_det_set: assert property (@(posedge pclk) disable iff (!presetn)
    poison.ib_posted || poison.ib_compl |=> sec_det)
    else $error("poisoned packet not logged");

  a_sec_mst_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !presp_en && !sec_mst |=> !sec_mst)
    else $error("master parity set while disabled");

  a_pri_mst_log: assert property (@(posedge pclk) disable iff (!presetn)
    poison.ob_compl |=> pri_mst && pri_det)
    else $error("outbound completion not logged");

  a_pri_posted: assert property (@(posedge pclk) disable iff (!presetn)
    poison.ob_posted && !poison.ob_compl && !pri_mst && !clr_pri |=> !pri_mst ##0 pri_det)
    else $error("posted poison wrongly logged");

  a_sec_fast_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && (idx == bmwd_pkg::IDX_SEC_STATUS) && (paddr[11:10] == 2'b00)
      |=> prdata[7:0] == 8'h00 ##1 !pready)
    else $error("secondary status low bits not zero");

  a_io_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && ((idx == bmwd_pkg::IDX_IO_BASE_UP) || (idx == bmwd_pkg::IDX_IO_LIM_UP))
      && (paddr[11:10] == 2'b00) |=> prdata == 32'h0 && !pslverr)
    else $error("upper I/O register not zero");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    |(irq_status & irq_enable) |=> irq)
    else $error("enabled status did not raise interrupt");

  a_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(irq_status & irq_enable)) |=> !irq)
    else $error("interrupt high with no enabled status");

  a_pf_window_off: assert property (@(posedge pclk) disable iff (!presetn)
    req.valid && (pf_lo > pf_hi) |=> !resp.pf_hit)
    else $error("disabled prefetchable window forwarded");

  a_sec_mst_set: assert property (@(posedge pclk) disable iff (!presetn)
    presp_en && (poison.ib_compl || poison.ib_write_poisoned) |=> sec_mst)
    else $error("enabled master parity event not logged");

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    access && !mapped |=> pslverr && pready && (prdata == 32'h0))
    else $error("unmapped access not refused");

  a_pready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");

endmodule : bmwd_top

// File: include/bmwd_pkg.sv
/*
  Shared constants and types for the bridge memory window decode block.
  Assumes a 32-bit APB master; every register index maps to byte address index*4.
*/
package bmwd_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PRI_STATUS = 8'h06;
  localparam logic [7:0] IDX_SEC_STATUS = 8'h1E;
  localparam logic [7:0] IDX_NP_BASE    = 8'h20;
  localparam logic [7:0] IDX_NP_LIMIT   = 8'h22;
  localparam logic [7:0] IDX_PF_BASE    = 8'h24;
  localparam logic [7:0] IDX_PF_LIMIT   = 8'h26;
  localparam logic [7:0] IDX_PF_BASE_UP = 8'h28;
  localparam logic [7:0] IDX_PF_LIM_UP  = 8'h2C;
  localparam logic [7:0] IDX_IO_BASE_UP = 8'h30;
  localparam logic [7:0] IDX_IO_LIM_UP  = 8'h32;
  localparam logic [7:0] IDX_BRIDGE_CTL = 8'h3E;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h41;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h42;

  // ==========================================================================
  // Field positions and reset values
  localparam int         FIELD_LSB      = 4;
  localparam int         DET_PARITY_BIT = 15;
  localparam int         MST_PARITY_BIT = 8;
  localparam int         FAST_CLK_BIT   = 5;
  localparam int         PRESP_EN_BIT   = 0;
  localparam logic [11:0] FIELD_RST     = 12'h000;
  localparam logic [3:0] WIDTH_32       = 4'h0;
  localparam logic [3:0] WIDTH_64       = 4'h1;
  localparam logic [3:0] PF_WIDTH_CODE  = WIDTH_64;
  localparam logic [31:0] UPPER_RST     = 32'h0000_0000;
  localparam logic [3:0] IRQ_RST        = 4'h0;

  // Interrupt status layout, one bit per parity flag.
  localparam int IRQ_PRI_DET = 0;
  localparam int IRQ_PRI_MST = 1;
  localparam int IRQ_SEC_DET = 2;
  localparam int IRQ_SEC_MST = 3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } bmwd_req_t;

  typedef struct packed {
    logic        valid;
    logic        np_hit;
    logic        pf_hit;
    logic        forward;
  } bmwd_resp_t;

  typedef struct packed {
    logic ob_posted;
    logic ob_compl;
    logic ib_posted;
    logic ib_compl;
    logic ib_write_poisoned;
  } bmwd_poison_t;

  function automatic logic [11:0] bmwd_byte_addr(input logic [7:0] idx);
    bmwd_byte_addr = {2'b00, idx, 2'b00};
  endfunction : bmwd_byte_addr

endpackage : bmwd_pkg

// File: bench/bmwd_far_model.sv
/*
  Far-side model: the upstream request source and the port's poison event source.
  Assumes the block samples both on every rising edge of pclk.
*/
`timescale 1ns/10ps
module bmwd_far_model (
  // Clock
  input  wire logic              pclk,
  // Towards the block
  output bmwd_pkg::bmwd_req_t    req,
  output bmwd_pkg::bmwd_poison_t poison
);
  initial begin
    req    = '0;
    poison = '0;
  end

  // ==========================================================================
  // Requests and events
  // A released address is inverted so that a stale value can never hit by luck.
  task automatic issue(input logic [63:0] a);
    @(posedge pclk);
    req <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    req <= '{valid: 1'b0, addr: ~a};
  endtask : issue

  task automatic pulse(input logic [4:0] v);
    @(posedge pclk);
    poison <= v;
    @(posedge pclk);
    poison <= '0;
  endtask : pulse
endmodule : bmwd_far_model

// File: bench/bridge_memory_window_decode_tb.sv
/*
  Self-checking bench: APB register access, window decode and parity logging.
  Assumes the block drives pready from a flop, so it is read once it has settled.
*/
`timescale 1ns/10ps
module bridge_memory_window_decode_tb;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [11:0]            paddr = '0;
  logic [31:0]            pwdata = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  bmwd_pkg::bmwd_req_t    req;
  bmwd_pkg::bmwd_resp_t   resp;
  bmwd_pkg::bmwd_poison_t poison;
  logic                   irq;
  int                     err_count = 0;
  int                     samples_checked = 0;

  always #4 pclk = ~pclk;

  bmwd_far_model bmwd_far_model_inst (.pclk(pclk), .req(req), .poison(poison));
  bmwd_top bmwd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .resp(resp), .poison(poison), .irq(irq));

  // ==========================================================================
  // Checking and closing
  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ==========================================================================
  // APB master: release only after pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Look just after each edge, where pready for the coming edge has settled.
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("MISMATCH pready expected 1 seen timeout");
      final_report();
    end
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
    check("write error", {31'h0, e}, 32'h0);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    check(what, r, exp);
    check("read error", {31'h0, e}, {31'h0, eexp});
  endtask : rd

  task automatic dec(input logic [63:0] a, input logic np, input logic pf);
    bmwd_far_model_inst.issue(a);
    #1;
    check("decode", {28'h0, resp}, {28'h0, 1'b1, np, pf, np | pf});
  endtask : dec

  // ==========================================================================
  // Tables
  logic [7:0]  ridx[6] = '{8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2C};
  logic [31:0] rrst[6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
  logic [31:0] rful[6] = '{32'hFFF0, 32'hFFF0, 32'hFFF1, 32'hFFF1, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [63:0] da[9] = '{64'h10000000, 64'h0FFFFFFF, 64'h1FFFFFFF, 64'h20000000, 64'h110000000,
                         64'h130000000, 64'h30000000, 64'h13FFFFFFF, 64'h140000000};
  logic [1:0]  dh[9] = '{2'b10, 2'b00, 2'b10, 2'b00, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00};
  // Expected {sec_mst, sec_det, pri_mst, pri_det} per event, without and with response enable.
  logic [3:0]  pex[2][5] = '{'{4'h1, 4'h3, 4'h4, 4'h4, 4'h0}, '{4'h1, 4'h3, 4'h4, 4'hC, 4'h8}};

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd("reset value", ridx[i], rrst[i], 1'b0);
    rd("secondary status", 8'h1E, 32'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(ridx[i], 32'hFFFFFFFF);
      rd("all ones", ridx[i], rful[i], 1'b0);
    end
    wr(8'h30, 32'hFFFF);
    rd("io upper", 8'h30, 32'h0, 1'b0);
    wr(8'h32, 32'hFFFF);
    rd("io upper", 8'h32, 32'h0, 1'b0);
    rd("unmapped", 8'h50, 32'h0, 1'b1);
    wr(8'h1E, 32'hFFFF);
    rd("secondary status", 8'h1E, 32'h0, 1'b0);
    // Windows kept apart from one another, as software must.
    wr(8'h20, 32'h1000);
    wr(8'h22, 32'h1FF0);
    wr(8'h24, 32'h3000);
    wr(8'h26, 32'h3FF0);
    wr(8'h28, 32'h1);
    wr(8'h2C, 32'h1);
    rd("pref base", 8'h24, 32'h3001, 1'b0);
    for (int i = 0; i < 9; i++) dec(da[i], dh[i][1], dh[i][0]);
    wr(8'h20, 32'h2000);
    dec(64'h1FF00000, 1'b0, 1'b0);
    dec(64'h20000000, 1'b0, 1'b0);
    wr(8'h24, 32'h4000);
    dec(64'h130000000, 1'b0, 1'b0);
    // Parity logging for each event, response enable off then on.
    wr(8'h42, 32'hF);
    for (int p = 0; p < 2; p++) begin
      wr(8'h3E, p);
      for (int k = 0; k < 5; k++) begin
        bmwd_far_model_inst.pulse(5'h10 >> k);
        repeat (2) @(posedge pclk);
        #1;
        check("irq", {31'h0, irq}, {31'h0, |pex[p][k]});
        rd("primary status", 8'h06, {16'h0, pex[p][k][0], 6'h0, pex[p][k][1], 8'h0}, 1'b0);
        rd("secondary status", 8'h1E, {16'h0, pex[p][k][2], 6'h0, pex[p][k][3], 8'h0}, 1'b0);
        rd("irq status", 8'h40, {28'h0, pex[p][k]}, 1'b0);
        wr(8'h06, 32'hFFFF);
        wr(8'h1E, 32'hFFFF);
        wr(8'h41, 32'hF);
        rd("secondary cleared", 8'h1E, 32'h0, 1'b0);
      end
    end
    rd("bridge control", 8'h3E, 32'h1, 1'b0);
    // A masked event still sets status but leaves the interrupt low.
    wr(8'h42, 32'hE);
    bmwd_far_model_inst.pulse(5'h10);
    repeat (2) @(posedge pclk);
    #1;
    check("masked irq", {31'h0, irq}, 32'h0);
    rd("irq status", 8'h40, 32'h1, 1'b0);
    rd("primary status", 8'h06, 32'h8000, 1'b0);
    wr(8'h41, 32'h1);
    rd("irq cleared", 8'h40, 32'h0, 1'b0);
    rd("clear reads zero", 8'h41, 32'h0, 1'b0);
    final_report();
  end
endmodule : bridge_memory_window_decode_tb
